// ===== hw/ccc_top.sv
// Camera capture channel 0 configuration, status and event logic
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module ccc_top
  import ccc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sensor_pclk,
  input wire logic sensor_vsync,
  input wire logic sensor_href,
  input wire logic sensor_field,
  input wire logic [2:0] fifo_overflow,
  input wire logic wrong_channel_write,
  input wire logic frame_written,
  output ccc_pixcfg_s pix_cfg,
  output logic [2:0][31:0] frame_base,
  output logic capturing,
  output logic irq
);

  // ----------------------------------------------------------------
  // Storage format decode
  // ----------------------------------------------------------------
  function automatic ccc_store_e ccc_decode(input logic [3:0] src, input logic [3:0] code);
    ccc_store_e k;
    k = ST_INVALID;
    if (src == SRC_RAW) begin
      case (code[2:0])
        3'h0: k = ST_RAW8;
        3'h1: k = ST_RAW10;
        3'h2: k = ST_RAW12;
        3'h4: k = ST_RGB565;
        3'h5: k = ST_RGB888;
        3'h6: k = ST_PRGB888;
        3'h7: k = ST_UVC_RAW;
        default: k = ST_INVALID;
      endcase
    end else if (src == SRC_YUV422) begin
      case (code)
        4'h0, 4'h3: k = ST_PLANAR422;
        4'h1, 4'h2: k = ST_PLANAR420;
        4'h4, 4'h7: k = ST_UVC422;
        4'h5, 4'h6: k = ST_UVC420;
        4'h8, 4'hB: k = ST_MB422;
        4'h9, 4'hA: k = ST_MB420;
        4'hC: k = ST_UVC10_422;
        4'hD: k = ST_UVC10_420;
        default: k = ST_INVALID;
      endcase
    end else if (src == SRC_YUV420) begin
      case (code)
        4'h1, 4'h2: k = ST_PLANAR420;
        4'h5, 4'h6: k = ST_UVC420;
        4'h9, 4'hA: k = ST_MB420;
        4'hD: k = ST_UVC10_420;
        default: k = ST_INVALID;
      endcase
    end
    return k;
  endfunction : ccc_decode

  function automatic logic [31:0] ccc_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return m;
  endfunction : ccc_merge

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccc_cfg_s cfg_reg;
  logic quarter_reg;
  logic [31:0] base_reg [FIFO_COUNT];
  logic [7:0] enable_reg;
  logic [7:0] pending_reg;
  logic [7:0] pending_next;
  logic [7:0] events;
  logic video_en_reg;
  logic bt656_reg;
  logic still_armed_reg;
  logic done_pending_reg;
  logic current_field_reg;
  ccc_cap_e state_reg;
  ccc_cap_e state_next;
  logic [2:0] ov_prev_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [3:0] pins_s;
  logic pclk_prev_reg;
  logic vs_smp_reg;
  logic hr_smp_reg;

  // ----------------------------------------------------------------
  // Sensor pin sampling
  // ----------------------------------------------------------------
  ccc_sync #(.WIDTH(4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({sensor_pclk, sensor_vsync, sensor_href, sensor_field}),
    .sync_out(pins_s)
  );

  // Pixel clock is slow enough to oversample; syncs are taken at its rising edge
  wire pclk_s = pins_s[3];
  wire vs_s = pins_s[2];
  wire hr_s = pins_s[1];
  wire fld_s = pins_s[0];
  wire pclk_rise = pclk_s & ~pclk_prev_reg;
  wire vsync_rise = pclk_rise & vs_s & ~vs_smp_reg;
  wire href_rise = pclk_rise & hr_s & ~hr_smp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_prev_reg <= 1'b0;
      vs_smp_reg <= 1'b0;
      hr_smp_reg <= 1'b0;
    end else begin
      pclk_prev_reg <= pclk_s;
      if (pclk_rise) begin
        vs_smp_reg <= vs_s;
        hr_smp_reg <= hr_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Format decode and pixel configuration
  // ----------------------------------------------------------------
  wire ccc_store_e kind = ccc_decode(cfg_reg.source_format, cfg_reg.storage_format);
  wire field_based = (cfg_reg.source_format == SRC_RAW) ? ~cfg_reg.storage_format[3]
                                                        : ~cfg_reg.storage_format[1];
  // Field 1 is low on the field pin, field 2 high
  wire field_ok = (cfg_reg.field_select == FSEL_ANY) ||
                  ((cfg_reg.field_select == FSEL_F1) && !fld_s) ||
                  ((cfg_reg.field_select == FSEL_F2) && fld_s);
  wire frame420 = (kind == ST_PLANAR420) && !field_based;
  // New field low means field 2 has just ended
  wire frame_edge = vsync_rise && (!(bt656_reg && frame420) || !fld_s);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_cfg <= '0;
    end else begin
      pix_cfg.storage_kind <= kind;
      pix_cfg.field_based <= field_based;
      pix_cfg.filler_byte <= cfg_reg.filler_byte;
      pix_cfg.filler_used <= (kind == ST_PRGB888);
      pix_cfg.vertical_mirror <= cfg_reg.vertical_mirror;
      pix_cfg.horizontal_mirror <= cfg_reg.horizontal_mirror;
      pix_cfg.component_order <= cfg_reg.component_order;
      pix_cfg.uv_first <= ~cfg_reg.component_order[0];
      pix_cfg.quarter_decimation <= quarter_reg;
    end
  end

  // ----------------------------------------------------------------
  // Capture sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CAP_IDLE: begin
        if (frame_edge && field_ok && still_armed_reg) begin
          state_next = CAP_STILL;
        end else if (frame_edge && field_ok && video_en_reg) begin
          state_next = CAP_VIDEO;
        end
      end
      CAP_VIDEO: begin
        if (frame_edge && !video_en_reg) begin
          state_next = CAP_IDLE;
        end
      end
      CAP_STILL: begin
        if (frame_edge) begin
          state_next = CAP_IDLE;
        end
      end
      default: state_next = CAP_IDLE;
    endcase
  end

  wire capture_ends = (state_reg != CAP_IDLE) && (state_next == CAP_IDLE);
  wire still_taken = (state_reg == CAP_IDLE) && (state_next == CAP_STILL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= CAP_IDLE;
      capturing <= 1'b0;
      current_field_reg <= 1'b0;
      done_pending_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      capturing <= (state_next != CAP_IDLE);
      if (vsync_rise) begin
        current_field_reg <= fld_s;
      end
      // A new end wins over the completion it would otherwise wait for
      done_pending_reg <= capture_ends | (done_pending_reg & ~frame_written);
    end
  end

  // Addresses are shadowed so a late software write cannot tear a frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_base <= '0;
    end else if (vsync_rise) begin
      for (int i = 0; i < FIFO_COUNT; i++) begin
        frame_base[i] <= base_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    events = 8'h00;
    events[EV_VS] = vsync_rise;
    events[EV_HB] = href_rise & (&fifo_overflow);
    events[EV_MUL] = wrong_channel_write;
    for (int i = 0; i < FIFO_COUNT; i++) begin
      events[EV_F0 + i] = fifo_overflow[i] & ~ov_prev_reg[i];
    end
    events[EV_FD] = frame_written & video_en_reg;
    events[EV_CD] = frame_written & done_pending_reg;
  end

  wire wr_fire = aw_held_reg & w_held_reg;
  wire wr_pend = wr_fire && (aw_addr_reg == ADDR_PEND);
  wire [7:0] pend_clear = wr_pend && w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
  // Hardware set wins over a software clear in the same cycle
  assign pending_next = (pending_reg & ~pend_clear) | events;
  assign irq = |(pending_reg & enable_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_reg <= 8'h00;
      ov_prev_reg <= 3'h0;
    end else begin
      pending_reg <= pending_next;
      ov_prev_reg <= fifo_overflow;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  wire wr_ctrl = wr_fire && (aw_addr_reg == ADDR_CTRL);
  wire wr_cfg = wr_fire && (aw_addr_reg == ADDR_CFG);
  wire wr_scale = wr_fire && (aw_addr_reg == ADDR_SCALE);
  wire wr_en = wr_fire && (aw_addr_reg == ADDR_EN);
  wire wr_sta = wr_fire && (aw_addr_reg == ADDR_STATUS);
  wire [2:0] wr_base;
  assign wr_base[0] = wr_fire && (aw_addr_reg == ADDR_BASE0);
  assign wr_base[1] = wr_fire && (aw_addr_reg == ADDR_BASE1);
  assign wr_base[2] = wr_fire && (aw_addr_reg == ADDR_BASE2);
  wire wr_hit = wr_ctrl | wr_cfg | wr_scale | wr_en | wr_sta | wr_pend | (|wr_base);
  wire [31:0] ctrl_merged = ccc_merge({29'h0, bt656_reg, video_en_reg, 1'b0}, w_data_reg, w_strb_reg);
  wire [31:0] cfg_merged = ccc_merge(cfg_reg, w_data_reg, w_strb_reg);
  wire still_req = wr_ctrl & ctrl_merged[CTRL_STILL];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= CFG_RESET;
      quarter_reg <= 1'b0;
      enable_reg <= EN_RESET;
      video_en_reg <= 1'b0;
      bt656_reg <= 1'b0;
      still_armed_reg <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= cfg_merged & 32'hFFFF_3F00;
      end
      if (wr_scale && w_strb_reg[0]) begin
        quarter_reg <= w_data_reg[SCALE_QUARTER];
      end
      if (wr_en && w_strb_reg[0]) begin
        enable_reg <= w_data_reg[7:0];
      end
      if (wr_ctrl) begin
        video_en_reg <= ctrl_merged[CTRL_VIDEO];
        bt656_reg <= ctrl_merged[CTRL_BT656];
      end
      // Re-arm wins over consuming the previous request
      still_armed_reg <= still_req | (still_armed_reg & ~still_taken);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < FIFO_COUNT; i++) begin
        base_reg[i] <= BASE_RESET;
      end
    end else begin
      for (int i = 0; i < FIFO_COUNT; i++) begin
        if (wr_base[i]) begin
          base_reg[i] <= ccc_merge(base_reg[i], w_data_reg, w_strb_reg);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == ADDR_CTRL) begin
      rd_data = {29'h0, bt656_reg, video_en_reg, 1'b0};
    end else if (s_axi_araddr == ADDR_CFG) begin
      rd_data = cfg_reg;
    end else if (s_axi_araddr == ADDR_SCALE) begin
      rd_data = {31'h0, quarter_reg};
    end else if (s_axi_araddr == ADDR_BASE0) begin
      rd_data = base_reg[0];
    end else if (s_axi_araddr == ADDR_BASE1) begin
      rd_data = base_reg[1];
    end else if (s_axi_araddr == ADDR_BASE2) begin
      rd_data = base_reg[2];
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_data = {29'h0, current_field_reg, state_reg == CAP_VIDEO, state_reg == CAP_STILL};
    end else if (s_axi_araddr == ADDR_EN) begin
      rd_data = {24'h0, enable_reg};
    end else if (s_axi_araddr == ADDR_PEND) begin
      rd_data = {24'h0, pending_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_vsync_event_set: assert property (vsync_rise |=> pending_reg[EV_VS])
    else $error("vsync did not set its event");
  a_base_latch_vsync: assert property (vsync_rise |=> frame_base[1] == $past(base_reg[1]))
    else $error("base address not latched at vsync");
  a_irq_enabled_event: assert property (frame_written && video_en_reg && enable_reg[EV_FD] |=> irq)
    else $error("enabled frame done did not raise interrupt");
  a_irq_masked_quiet: assert property ((pending_reg & enable_reg) == 8'h00 |-> !irq)
    else $error("interrupt without enabled pending event");
  a_still_self_clear: assert property (state_reg == CAP_STILL && frame_edge |=> state_reg == CAP_IDLE ##1 !capturing || state_reg != CAP_IDLE)
    else $error("still capture did not end after one frame");
  a_video_stop_end: assert property (state_reg == CAP_VIDEO && frame_edge && !video_en_reg |=> state_reg == CAP_IDLE)
    else $error("video capture did not stop at frame end");
  a_start_at_frame: assert property ($rose(capturing) |-> $past(frame_edge))
    else $error("capture started off a frame boundary");
  a_blank_overflow: assert property (href_rise && (&fifo_overflow) |=> pending_reg[EV_HB])
    else $error("blanking overflow event missing");
  a_capture_done: assert property (done_pending_reg && frame_written |=> pending_reg[EV_CD])
    else $error("capture done event missing");
  a_field_status: assert property (vsync_rise |=> current_field_reg == $past(fld_s))
    else $error("field status not updated at vsync");
  a_filler_prgb: assert property (pix_cfg.filler_used |-> pix_cfg.storage_kind == ST_PRGB888)
    else $error("filler used outside packed rgb888");

endmodule : ccc_top

// ===== hw/ccc_pkg.sv
// Shared constants and types of the camera capture channel configuration block
package ccc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h44;
  localparam logic [7:0] ADDR_SCALE = 8'h4C;
  localparam logic [7:0] ADDR_BASE0 = 8'h50;
  localparam logic [7:0] ADDR_BASE1 = 8'h58;
  localparam logic [7:0] ADDR_BASE2 = 8'h60;
  localparam logic [7:0] ADDR_STATUS = 8'h6C;
  localparam logic [7:0] ADDR_EN = 8'h70;
  localparam logic [7:0] ADDR_PEND = 8'h74;
  localparam int FIFO_COUNT = 3;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_RESET = 32'h0030_0200;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam int CTRL_STILL = 0;
  localparam int CTRL_VIDEO = 1;
  localparam int CTRL_BT656 = 2;
  localparam int SCALE_QUARTER = 0;
  localparam int STA_SINGLE = 0;
  localparam int STA_VIDEO = 1;
  localparam int STA_FIELD = 2;
  localparam int EV_CD = 0;
  localparam int EV_FD = 1;
  localparam int EV_F0 = 2;
  localparam int EV_MUL = 5;
  localparam int EV_HB = 6;
  localparam int EV_VS = 7;
  localparam int EV_COUNT = 8;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_RAW = 4'h0;
  localparam logic [3:0] SRC_YUV422 = 4'h3;
  localparam logic [3:0] SRC_YUV420 = 4'h4;
  localparam logic [1:0] FSEL_F1 = 2'h0;
  localparam logic [1:0] FSEL_F2 = 2'h1;
  localparam logic [1:0] FSEL_ANY = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_INVALID = 5'h00,
    ST_RAW8 = 5'h01,
    ST_RAW10 = 5'h02,
    ST_RAW12 = 5'h03,
    ST_RGB565 = 5'h04,
    ST_RGB888 = 5'h05,
    ST_PRGB888 = 5'h06,
    ST_UVC_RAW = 5'h07,
    ST_PLANAR422 = 5'h08,
    ST_PLANAR420 = 5'h09,
    ST_UVC422 = 5'h0A,
    ST_UVC420 = 5'h0B,
    ST_MB422 = 5'h0C,
    ST_MB420 = 5'h0D,
    ST_UVC10_422 = 5'h0E,
    ST_UVC10_420 = 5'h0F
  } ccc_store_e;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_VIDEO = 2'b01,
    CAP_STILL = 2'b10
  } ccc_cap_e;

  typedef struct packed {
    logic [7:0] filler_byte;
    logic [3:0] source_format;
    logic [3:0] storage_format;
    logic [1:0] rsv_hi;
    logic vertical_mirror;
    logic horizontal_mirror;
    logic [1:0] field_select;
    logic [1:0] component_order;
    logic [7:0] rsv_lo;
  } ccc_cfg_s;

  typedef struct packed {
    ccc_store_e storage_kind;
    logic field_based;
    logic [7:0] filler_byte;
    logic filler_used;
    logic vertical_mirror;
    logic horizontal_mirror;
    logic [1:0] component_order;
    logic uv_first;
    logic quarter_decimation;
  } ccc_pixcfg_s;

endpackage : ccc_pkg

// ===== hw/ccc_sync.sv
// Two-flop synchroniser for sensor pins
`timescale 1ns/1ps
module ccc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------
  // Only the second stage is visible outside
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : ccc_sync

// ===== tb/ccc_sensor.sv
// Parallel sensor model driving syncs and pixel clock
`timescale 1ns/1ps
module ccc_sensor (
  output logic pclk,
  output logic vsync,
  output logic href,
  output logic field
);
  initial begin
    {pclk, vsync, href, field} = 4'h0;
  end
  // Clock stands still between frames, as a gated sensor clock does
  task automatic tick(input int n);
    repeat (n) begin
      #24 pclk = 1'b1;
      #24 pclk = 1'b0;
    end
  endtask : tick
  task automatic frame(input logic f);
    // Off the bench clock's edges for every later pin change
    #1.25;
    field = f;
    vsync = 1'b1;
    tick(3);
    vsync = 1'b0;
    href = 1'b1;
    tick(8);
    href = 1'b0;
    tick(3);
  endtask : frame
endmodule : ccc_sensor

// ===== tb/testbench.sv
// Self-checking bench of the capture channel configuration block
`timescale 1ns/1ps
module testbench;
  import ccc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, x, d, s = 32'h308640BD;
  logic [31:0] bs [3];
  logic [2:0] ov, fov = 3'h0;
  logic wcw = 1'b0, fw = 1'b0, awr, wr_, bv, arr, rv, pclk, vs, hr, fl, cap, irq;
  logic [1:0] br, rr, r;
  logic [31:0] rd_;
  ccc_pixcfg_s pc;
  logic [2:0][31:0] fb;
  int errors = 0, tests_run = 0;
  logic [7:0] ra [7] = '{ADDR_CFG, ADDR_SCALE, ADDR_BASE0, ADDR_BASE1, ADDR_BASE2, ADDR_STATUS, ADDR_EN};
  logic [31:0] rs [7] = '{CFG_RESET, 32'h0, BASE_RESET, BASE_RESET, BASE_RESET, 32'h0, 32'h0};
  logic [31:0] dc [4] = '{32'h000E_0000, 32'h0030_0000, 32'h0040_0000, 32'h0041_0800};
  logic [31:0] dk [4] = '{ST_PRGB888, ST_PLANAR422, ST_INVALID, ST_PLANAR420};
  ccc_sensor i_sen (.pclk(pclk), .vsync(vs), .href(hr), .field(fl));
  ccc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .sensor_pclk(pclk),
    .sensor_vsync(vs), .sensor_href(hr), .sensor_field(fl), .fifo_overflow(fov), .wrong_channel_write(wcw),
    .frame_written(fw), .pix_cfg(pc), .frame_base(fb), .capturing(cap), .irq(irq));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  // Handshakes sampled at the falling edge, settled until the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    {awa, wd, awv, wv, bry} <= {a, v, 3'h7};
    repeat (50) begin
      @(negedge aclk);
      {ta, tw, tb, r} = {awv & awr, wv & wr_, bv, br};
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) break;
    end
    if (!tb) errors++;
    bry <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    {ara, arv, rry} <= {a, 2'h3};
    repeat (50) begin
      @(negedge aclk);
      {ta, tr, d, r} = {arv & arr, rv, rd_, rr};
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tr) break;
    end
    if (!tr) errors++;
    rry <= 1'b0;
  endtask : rd
  task automatic rck(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, d);
  endtask : rck
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step
  task automatic end_of_test();
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    step(2);
    aresetn <= 1'b1;
    foreach (ra[i]) rck("reset", ra[i], rs[i]);
    rd(8'h04);
    chk("unmapped", RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    x = xs();
    wr(ADDR_CFG, x);
    rck("cfg", ADDR_CFG, x & 32'hFFFF3F00);
    wr(ADDR_SCALE, 32'h1);
    rck("scale", ADDR_SCALE, 32'h1);
    chk("mirror", x[13:12], {pc.vertical_mirror, pc.horizontal_mirror});
    chk("uv first", !x[8], pc.uv_first);
    chk("quarter", 1'b1, pc.quarter_decimation);
    for (int i = 0; i < FIFO_COUNT; i++) begin
      bs[i] = xs();
      wr(8'(ADDR_BASE0 + 8 * i), bs[i]);
      rck("base", 8'(ADDR_BASE0 + 8 * i), bs[i]);
    end
    foreach (dc[i]) begin
      wr(ADDR_CFG, dc[i]);
      step(2);
      chk("kind", dk[i], pc.storage_kind);
    end
    wr(ADDR_EN, 32'hFF);
    wr(ADDR_CTRL, 32'h2);
    rck("status", ADDR_STATUS, 32'h0);
    i_sen.frame(1'b0);
    step(10);
    for (int i = 0; i < FIFO_COUNT; i++) chk("base latch", bs[i], fb[i]);
    rck("status", ADDR_STATUS, 32'h2);
    chk("irq", 1'b1, irq);
    // Never all three queues at once; with no line start here the blanking event stays clear anyway
    ov = 3'(xs() % 6 + 1);
    {fov, wcw, fw} <= {ov, 2'h3};
    step(1);
    {wcw, fw} <= 2'h0;
    step(4);
    rck("pending", ADDR_PEND, {24'h0, 8'hA2 | 8'(ov << 2)});
    wr(ADDR_PEND, 32'hFF);
    rck("pending", ADDR_PEND, 32'h0);
    chk("irq", 1'b0, irq);
    wr(ADDR_EN, 32'h0);
    {fov, wcw} <= 4'h1;
    step(1);
    wcw <= 1'b0;
    step(3);
    chk("irq masked", 1'b0, irq);
    wr(ADDR_CTRL, 32'h0);
    i_sen.frame(1'b1);
    step(10);
    rck("status", ADDR_STATUS, 32'h4);
    chk("capturing", 1'b0, cap);
    fw <= 1'b1;
    step(1);
    fw <= 1'b0;
    step(3);
    rck("pending", ADDR_PEND, 32'hA1);
    // All three queues full across the coming line start
    fov <= 3'h7;
    wr(ADDR_CTRL, 32'h1);
    i_sen.frame(1'b0);
    step(10);
    rck("still", ADDR_STATUS, 32'h1);
    rck("pending", ADDR_PEND, 32'hFD);
    i_sen.frame(1'b0);
    step(10);
    rck("still", ADDR_STATUS, 32'h0);
    wr(ADDR_CFG, 32'h0042_0800);
    wr(ADDR_CTRL, 32'h6);
    i_sen.frame(1'b1);
    step(10);
    rck("bt656", ADDR_STATUS, 32'h4);
    i_sen.frame(1'b0);
    step(10);
    rck("bt656", ADDR_STATUS, 32'h2);
    end_of_test();
  end
endmodule : testbench
